// *** common/vsr_cfg.svh ***
// Offsets, field positions and reset values of the eye-tuning register bank
`ifndef VSR_CFG_SVH
`define VSR_CFG_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define VSR_ADDR_EYE 8'h80
`define VSR_ADDR_SET 8'h81
`define VSR_ADDR_CLR 8'h82
`define VSR_ADDR_STS 8'h83

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define VSR_POL_BIT 6
`define VSR_ZHS_HI 5
`define VSR_ZHS_LO 4
`define VSR_IHS_HI 3
`define VSR_IHS_LO 0
`define VSR_BOOST_BIT 0
`define VSR_STS_RSVD_BIT 7

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define VSR_EYE_RST_SPARE 1'h0
`define VSR_EYE_RST_POL 1'h1
`define VSR_EYE_RST_ZHS 2'h0
`define VSR_EYE_RST_IHS 4'h1
`define VSR_MON_RST 7'h00
`define VSR_UNMAPPED_RD 8'h00

`endif

// *** common/vsr_pkg.sv ***
// Types shared by the eye-tuning register bank
`default_nettype none
package vsr_pkg;

    typedef struct packed
    {
        logic spare;
        logic polarity;
        logic [1:0] zhs;
        logic [3:0] ihs;
    } vsr_eye_t;

    // Ordered so that the packed value is status bits 6..0
    typedef struct packed
    {
        logic usb_input_supply_ok;
        logic abnormal_stress_det;
        logic id_pin_floating;
        logic id_resistance_det_c;
        logic id_resistance_det_b;
        logic id_resistance_det_a;
        logic vbus_session_valid;
    } vsr_mon_t;

    typedef struct packed
    {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vsr_req_t;

    typedef enum logic [1:0]
    {
        VSR_L_IDLE = 2'b01,
        VSR_L_WAIT = 2'b10
    } vsr_lstate_t;

endpackage
`default_nettype wire

// *** logic/vsr_regs.sv ***
// Eye-tuning set/clear aliases and live monitor status register bank
`timescale 1ns/1ps
`default_nettype none
`include "vsr_cfg.svh"

module vsr_regs
(
    input wire logic sys_clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic link_clk, // Link interface clock
    input wire logic lnk_req, // Request strobe, link domain
    input wire vsr_pkg::vsr_req_t lnk_cmd, // Request write flag/address/data
    output logic lnk_busy, // Request in flight
    output logic lnk_ack, // Access done pulse
    output logic [7:0] lnk_rdata, // Read data, valid with lnk_ack
    input wire vsr_pkg::vsr_mon_t mon_in, // Asynchronous monitor levels
    output logic line_polarity_swap, // Data-line polarity control
    output logic [1:0] hs_output_impedance_sel, // HS output impedance
    output logic [3:0] hs_drive_current_sel, // HS drive current
    output logic ac_boost_en // AC boost enable
);
    import vsr_pkg::*;

    // -----------------------------------------------------------------------
    // Link domain: reset sync, request capture, answer pickup
    // -----------------------------------------------------------------------
    logic lrst_s1_ff;
    logic lrst_ff;
    vsr_lstate_t lstate_ff;
    vsr_req_t hold_ff;
    logic req_tgl_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic ack_seen_ff;
    logic lnk_ack_ff;
    logic [7:0] lnk_rdata_ff;
    logic nxt_lrst_s1;
    logic nxt_lrst;
    vsr_lstate_t nxt_lstate;
    vsr_req_t nxt_hold;
    logic nxt_req_tgl;
    logic nxt_ack_s1;
    logic nxt_ack_s2;
    logic nxt_ack_seen;
    logic nxt_lnk_ack;
    logic [7:0] nxt_lnk_rdata;

    // Core-domain state the link side reads across the crossing
    logic ack_tgl_ff;
    logic [7:0] rdata_ff;

    always_comb
    begin
        nxt_lrst_s1 = srst;
        nxt_lrst = lrst_s1_ff;
        nxt_lstate = lstate_ff;
        nxt_hold = hold_ff;
        nxt_req_tgl = req_tgl_ff;
        nxt_ack_s1 = ack_tgl_ff;
        nxt_ack_s2 = ack_s1_ff;
        nxt_ack_seen = ack_s2_ff;
        nxt_lnk_ack = 1'b0;
        nxt_lnk_rdata = lnk_rdata_ff;
        if (lrst_ff)
        begin
            nxt_lstate = VSR_L_IDLE;
            nxt_hold = '0;
            nxt_req_tgl = 1'b0;
            nxt_ack_s1 = 1'b0;
            nxt_ack_s2 = 1'b0;
            nxt_ack_seen = 1'b0;
            nxt_lnk_rdata = 8'h00;
        end
        else
        begin
            case (lstate_ff)
                VSR_L_IDLE:
                begin
                    // Hold stays frozen until the answer returns, so the
                    // core may read it as a quasi-static word
                    if (lnk_req)
                    begin
                        nxt_hold = lnk_cmd;
                        nxt_req_tgl = ~req_tgl_ff;
                        nxt_lstate = VSR_L_WAIT;
                    end
                end
                VSR_L_WAIT:
                begin
                    if (ack_s2_ff != ack_seen_ff)
                    begin
                        nxt_lnk_rdata = rdata_ff;
                        nxt_lnk_ack = 1'b1;
                        nxt_lstate = VSR_L_IDLE;
                    end
                end
                default:
                begin
                    nxt_lstate = VSR_L_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk)
    begin
        lrst_s1_ff <= nxt_lrst_s1;
        lrst_ff <= nxt_lrst;
        lstate_ff <= nxt_lstate;
        hold_ff <= nxt_hold;
        req_tgl_ff <= nxt_req_tgl;
        ack_s1_ff <= nxt_ack_s1;
        ack_s2_ff <= nxt_ack_s2;
        ack_seen_ff <= nxt_ack_seen;
        lnk_ack_ff <= nxt_lnk_ack;
        lnk_rdata_ff <= nxt_lnk_rdata;
    end

    assign lnk_busy = (lstate_ff != VSR_L_IDLE);
    assign lnk_ack = lnk_ack_ff;
    assign lnk_rdata = lnk_rdata_ff;

    // -----------------------------------------------------------------------
    // Core domain: monitor sync, register file
    // -----------------------------------------------------------------------
    vsr_mon_t mon_s1_ff;
    vsr_mon_t mon_ff;
    logic req_s1_ff;
    logic req_s2_ff;
    logic req_seen_ff;
    vsr_eye_t eye_ff;
    vsr_mon_t nxt_mon_s1;
    vsr_mon_t nxt_mon;
    logic nxt_req_s1;
    logic nxt_req_s2;
    logic nxt_req_seen;
    vsr_eye_t nxt_eye;
    logic [7:0] nxt_rdata;
    logic nxt_ack_tgl;
    logic acc_go;
    logic [7:0] rd_val;

    assign acc_go = (req_s2_ff != req_seen_ff);

    always_comb
    begin
        case (hold_ff.addr)
            `VSR_ADDR_EYE,
            `VSR_ADDR_SET,
            `VSR_ADDR_CLR: rd_val = eye_ff;
            `VSR_ADDR_STS: rd_val = {1'b0, mon_ff};
            default: rd_val = `VSR_UNMAPPED_RD;
        endcase
    end

    always_comb
    begin
        nxt_mon_s1 = mon_in;
        nxt_mon = mon_s1_ff;
        nxt_req_s1 = req_tgl_ff;
        nxt_req_s2 = req_s1_ff;
        nxt_req_seen = req_s2_ff;
        nxt_eye = eye_ff;
        nxt_rdata = rdata_ff;
        nxt_ack_tgl = ack_tgl_ff;
        if (srst)
        begin
            nxt_mon_s1 = `VSR_MON_RST;
            nxt_mon = `VSR_MON_RST;
            nxt_req_s1 = 1'b0;
            nxt_req_s2 = 1'b0;
            nxt_req_seen = 1'b0;
            nxt_eye.spare = `VSR_EYE_RST_SPARE;
            nxt_eye.polarity = `VSR_EYE_RST_POL;
            nxt_eye.zhs = `VSR_EYE_RST_ZHS;
            nxt_eye.ihs = `VSR_EYE_RST_IHS;
            nxt_rdata = 8'h00;
            nxt_ack_tgl = 1'b0;
        end
        else if (acc_go)
        begin
            // Read value is taken before the write lands
            nxt_rdata = rd_val;
            nxt_ack_tgl = ~ack_tgl_ff;
            if (hold_ff.we)
            begin
                case (hold_ff.addr)
                    `VSR_ADDR_EYE: nxt_eye = hold_ff.wdata;
                    `VSR_ADDR_SET: nxt_eye = eye_ff | hold_ff.wdata;
                    `VSR_ADDR_CLR: nxt_eye = eye_ff & ~hold_ff.wdata;
                    default: nxt_eye = eye_ff;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        mon_s1_ff <= nxt_mon_s1;
        mon_ff <= nxt_mon;
        req_s1_ff <= nxt_req_s1;
        req_s2_ff <= nxt_req_s2;
        req_seen_ff <= nxt_req_seen;
        eye_ff <= nxt_eye;
        rdata_ff <= nxt_rdata;
        ack_tgl_ff <= nxt_ack_tgl;
    end

    assign line_polarity_swap = eye_ff.polarity;
    assign hs_output_impedance_sel = eye_ff.zhs;
    assign hs_drive_current_sel = eye_ff.ihs;
    assign ac_boost_en = eye_ff[`VSR_BOOST_BIT];

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    property p_set_alias;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_SET) |=>
            (eye_ff == ($past(eye_ff) | $past(hold_ff.wdata)));
    endproperty
    a_set_alias: assert property (p_set_alias)
        else $error("set alias write wrong");

    property p_clr_alias;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_CLR) |=>
            (eye_ff == ($past(eye_ff) & ~$past(hold_ff.wdata)));
    endproperty
    a_clr_alias: assert property (p_clr_alias)
        else $error("clear alias write wrong");

    property p_alias_read;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && !hold_ff.we && (hold_ff.addr == `VSR_ADDR_SET ||
            hold_ff.addr == `VSR_ADDR_CLR)) |=> (rdata_ff == $past(eye_ff));
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("alias read not control value");

    property p_sts_read;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && !hold_ff.we && hold_ff.addr == `VSR_ADDR_STS) |=>
            (rdata_ff == {1'b0, $past(mon_ff)});
    endproperty
    a_sts_read: assert property (p_sts_read)
        else $error("status read not live value");

    sequence s_no_rst2;
        !$past(srst) && !$past(srst, 2);
    endsequence

    property p_sts_vbus;
        @(posedge sys_clk) disable iff (srst)
        s_no_rst2 |->
            (mon_ff.vbus_session_valid == $past(mon_in.vbus_session_valid, 2));
    endproperty
    a_sts_vbus: assert property (p_sts_vbus)
        else $error("status bit 0 not tracking session valid");

    property p_sts_idres;
        @(posedge sys_clk) disable iff (srst)
        s_no_rst2 |-> ({mon_ff.id_resistance_det_c, mon_ff.id_resistance_det_b,
            mon_ff.id_resistance_det_a} == $past({mon_in.id_resistance_det_c,
            mon_in.id_resistance_det_b, mon_in.id_resistance_det_a}, 2));
    endproperty
    a_sts_idres: assert property (p_sts_idres)
        else $error("status bits 1-3 not tracking ID detectors");

    property p_sts_float;
        @(posedge sys_clk) disable iff (srst)
        s_no_rst2 |->
            (mon_ff.id_pin_floating == $past(mon_in.id_pin_floating, 2));
    endproperty
    a_sts_float: assert property (p_sts_float)
        else $error("status bit 4 not tracking ID floating");

    property p_sts_stress;
        @(posedge sys_clk) disable iff (srst)
        $fell(srst) |-> (mon_ff.abnormal_stress_det == 1'b0) ##2
            (mon_ff.abnormal_stress_det == $past(mon_in.abnormal_stress_det, 2));
    endproperty
    a_sts_stress: assert property (p_sts_stress)
        else $error("status bit 5 reset or tracking wrong");

    property p_sts_supply;
        @(posedge sys_clk) disable iff (srst)
        $fell(srst) |-> (mon_ff.usb_input_supply_ok == 1'b0) ##2
            (mon_ff.usb_input_supply_ok == $past(mon_in.usb_input_supply_ok, 2));
    endproperty
    a_sts_supply: assert property (p_sts_supply)
        else $error("status bit 6 reset or tracking wrong");

    property p_sts_wr_ignored;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_STS) |=>
            ($stable(eye_ff) && !rdata_ff[`VSR_STS_RSVD_BIT]);
    endproperty
    a_sts_wr_ignored: assert property (p_sts_wr_ignored)
        else $error("status write changed state");

    property p_eye_reset;
        @(posedge sys_clk) disable iff (srst)
        $fell(srst) |-> (line_polarity_swap && hs_output_impedance_sel == 2'h0
            && hs_drive_current_sel == 4'h1 && !eye_ff.spare);
    endproperty
    a_eye_reset: assert property (p_eye_reset)
        else $error("control reset value wrong");

    property p_boost_clr;
        @(posedge sys_clk) disable iff (srst)
        (acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_CLR &&
            hold_ff.wdata[`VSR_BOOST_BIT]) |=> !ac_boost_en;
    endproperty
    a_boost_clr: assert property (p_boost_clr)
        else $error("AC boost still enabled after clear");

    c_set_wr: cover property (@(posedge sys_clk) disable iff (srst)
        acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_SET);
    c_clr_wr: cover property (@(posedge sys_clk) disable iff (srst)
        acc_go && hold_ff.we && hold_ff.addr == `VSR_ADDR_CLR);
    c_sts_rd: cover property (@(posedge sys_clk) disable iff (srst)
        acc_go && !hold_ff.we && hold_ff.addr == `VSR_ADDR_STS);
    c_lnk_ack: cover property (@(posedge link_clk) disable iff (lrst_ff)
        lnk_ack);

endmodule // vsr_regs
`default_nettype wire

// *** test/test_vsr_regs.sv ***
// Self-checking bench of the eye-tuning register bank
`timescale 1ns/1ps
`default_nettype none
`include "vsr_cfg.svh"
module test_vsr_regs;
    import vsr_pkg::*;
    logic sys_clk, link_clk, srst, lnk_req, lnk_busy, lnk_ack;
    logic line_polarity_swap, ac_boost_en;
    logic [1:0] hs_output_impedance_sel;
    logic [3:0] hs_drive_current_sel;
    logic [7:0] lnk_rdata;
    vsr_req_t lnk_cmd;
    vsr_mon_t mon_in;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hF2DD336E;
    logic [7:0] ctrl = 8'h41;
    logic [7:0] tbl [6] = '{`VSR_ADDR_EYE, `VSR_ADDR_SET, `VSR_ADDR_CLR,
        `VSR_ADDR_STS, 8'h7F, 8'hC3};

    vsr_regs dut (.sys_clk(sys_clk), .srst(srst), .link_clk(link_clk),
        .lnk_req(lnk_req), .lnk_cmd(lnk_cmd), .lnk_busy(lnk_busy),
        .lnk_ack(lnk_ack), .lnk_rdata(lnk_rdata), .mon_in(mon_in),
        .line_polarity_swap(line_polarity_swap),
        .hs_output_impedance_sel(hs_output_impedance_sel),
        .hs_drive_current_sel(hs_drive_current_sel),
        .ac_boost_en(ac_boost_en));
    vsr_link_model link (.link_clk(link_clk), .lnk_busy(lnk_busy),
        .lnk_ack(lnk_ack), .lnk_rdata(lnk_rdata), .lnk_req(lnk_req),
        .lnk_cmd(lnk_cmd));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end

    // ------------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == `VSR_ADDR_STS)
            return {1'b0, mon_in};
        if (a inside {`VSR_ADDR_EYE, `VSR_ADDR_SET, `VSR_ADDR_CLR})
            return ctrl;
        return `VSR_UNMAPPED_RD;
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp(got, exp);
    endtask
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        cmp(got, exp);
    endtask

    task automatic summarize;
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Writes answer with the value read before the write lands
    task automatic acc(input logic we, input logic [7:0] a,
        input logic [7:0] wd, input int gap, input bit poke);
        logic [7:0] rd;
        logic [7:0] exp;
        logic [7:0] outs;
        exp = exp_rd(a);
        link.access(we, a, wd, gap, poke, rd);
        if (we)
            case (a)
                `VSR_ADDR_EYE: ctrl = wd;
                `VSR_ADDR_SET: ctrl = ctrl | wd;
                `VSR_ADDR_CLR: ctrl = ctrl & ~wd;
                default: ;
            endcase
        outs = {ac_boost_en, line_polarity_swap, hs_output_impedance_sel,
            hs_drive_current_sel};
        chk_rd(rd, exp);
        chk_out(outs, {ctrl[0], ctrl[6:0]});
        chk_out({6'h00, link.took_busy, lnk_busy}, 8'h02);
    endtask

    // Monitors pass two sync flops; four cycles leaves margin
    task automatic set_mon(input logic [6:0] m);
        @(posedge sys_clk);
        #1;
        mon_in = m;
        repeat (4) @(posedge sys_clk);
        @(posedge link_clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [7:0] a;
        srst = 1'b1;
        mon_in = '0;
        // Longer than eleven cycles so the link side sees three edges
        repeat (16) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        repeat (5) @(posedge link_clk);
        #1;
        for (int i = 0; i < 4; i++)
            acc(1'b0, tbl[i], 8'h00, 0, 1'b0);
        acc(1'b1, `VSR_ADDR_SET, 8'h00, 0, 1'b0);
        acc(1'b1, `VSR_ADDR_CLR, 8'h00, 0, 1'b0);
        acc(1'b1, `VSR_ADDR_CLR, 8'h41, 0, 1'b1);
        acc(1'b1, `VSR_ADDR_SET, 8'hB6, 0, 1'b0);
        acc(1'b1, `VSR_ADDR_STS, 8'hFF, 1, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            set_mon(7'h01 << i);
            acc(1'b0, `VSR_ADDR_STS, 8'h00, 0, 1'b0);
        end
        for (int k = 0; k < 60; k++)
        begin
            repeat (8) seed = lfsr(seed);
            if (seed[8])
                set_mon(seed[30:24]);
            a = tbl[seed[12:10] % 6];
            acc(seed[9], a, seed[7:0], seed[14:13], seed[16]);
        end
        summarize();
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            summarize();
        end
    end
endmodule // test_vsr_regs
`default_nettype wire

// *** test/vsr_link_model.sv ***
// Link controller model issuing register accesses over the request port
`timescale 1ns/1ps
`default_nettype none
module vsr_link_model
(
    input wire logic link_clk, // Link clock
    input wire logic lnk_busy, // Request in flight
    input wire logic lnk_ack, // Access done pulse
    input wire logic [7:0] lnk_rdata, // Read data
    output logic lnk_req, // Request strobe
    output vsr_pkg::vsr_req_t lnk_cmd // Request fields
);
    import vsr_pkg::*;

    // Busy level seen 1 ns after the taking edge, for the bench
    logic took_busy;

    initial
    begin
        lnk_req = 1'b0;
        lnk_cmd = '0;
    end

    // ------------------------------------------------------------------
    // One access; entered and left just after a link edge
    // ------------------------------------------------------------------
    // The fields toggle every busy cycle (the first holds the stray write when poke is set) so a stale capture cannot pass
    task automatic access(input logic we, input logic [7:0] addr,
        input logic [7:0] wd, input int gap, input bit poke,
        output logic [7:0] rd);
        int n;
        repeat (gap)
        begin
            @(posedge link_clk);
            #1;
        end
        lnk_req = 1'b1;
        lnk_cmd = '{we: we, addr: addr, wdata: wd};
        @(posedge link_clk);
        #1;
        took_busy = lnk_busy;
        // Stray write while busy; the port must drop it
        lnk_req = poke & lnk_busy;
        lnk_cmd = poke ? vsr_req_t'{1'b1, 8'h80, 8'hFF} : ~lnk_cmd;
        for (n = 0; n < 10; n++)
        begin
            @(posedge link_clk);
            if (lnk_ack === 1'b1)
                break;
            #1;
            lnk_req = 1'b0;
            lnk_cmd = ~lnk_cmd;
        end
        rd = (n < 10) ? lnk_rdata : 8'hXX;
        #1;
    endtask
endmodule // vsr_link_model
`default_nettype wire
